// [rtl/ulsl_pkg.sv]
// package of the uart line status block: register map, bit positions,
// reset values, timing counts and the packed carriers.
// assumes a 10 MHz clock and a 32-bit classic wishbone register bus.
package ulsl_pkg;

	// register byte offsets (printed index times four)
	localparam logic [7:0] ULSL_IDX_LINE_STATUS = 8'h05;
	localparam logic [7:0] ULSL_ADR_LINE_STATUS = 8'h14;
	localparam logic [7:0] ULSL_ADR_INT_IDENT = 8'h20;
	localparam logic [7:0] ULSL_ADR_CTRL = 8'h24;
	localparam logic [7:0] ULSL_ADR_IRQ_STATUS = 8'h28;
	localparam logic [7:0] ULSL_ADR_IRQ_MASK = 8'h2c;

	// line status bit positions
	localparam int ULSL_B_DATA_READY = 0;
	localparam int ULSL_B_OVERRUN = 1;
	localparam int ULSL_B_PARITY = 2;
	localparam int ULSL_B_FRAMING = 3;
	localparam int ULSL_B_BREAK = 4;
	localparam int ULSL_B_THR_EMPTY = 5;
	localparam int ULSL_B_TX_EMPTY = 6;
	localparam int ULSL_B_FIFO_ERR = 7;

	// control register bit positions
	localparam int ULSL_C_FIFO_MODE = 0;
	localparam int ULSL_C_RLS_EN = 1;
	localparam int ULSL_C_TX_HOLDING_EMPTY_FLAG_EN = 2;
	localparam int ULSL_C_PARITY_EVEN = 3;
	localparam int ULSL_C_PARITY_ON = 4;

	// interrupt status/mask bit positions
	localparam int ULSL_I_RLS = 0;
	localparam int ULSL_I_TX_HOLDING_EMPTY_FLAG = 1;
	localparam int ULSL_I_DATA = 2;

	// reset values
	localparam logic [7:0] ULSL_LSR_RESET = 8'h60;
	localparam logic [4:0] ULSL_CTRL_RESET = 5'h00;
	localparam logic [2:0] ULSL_IRQ_RESET = 3'h0;

	// int_ident codes
	localparam logic [3:0] ULSL_IID_NONE = 4'h1;
	localparam logic [3:0] ULSL_IID_RLS = 4'h6;
	localparam logic [3:0] ULSL_IID_TX_HOLDING_EMPTY_FLAG = 4'h2;

	// rx fifo depth
	localparam int ULSL_FIFO_DEPTH = 16;
	localparam int ULSL_PTR_W = 4;
	localparam logic [4:0] ULSL_FIFO_FULL = 5'h10;

	// break: one full character time of low line, in ns and in cycles
	localparam int ULSL_CLK_NS = 100;
	localparam int ULSL_CHAR_NS = 1041700;
	localparam int ULSL_CHAR_CYC = ULSL_CHAR_NS / ULSL_CLK_NS;
	localparam int ULSL_BRK_W = 14;

	// character from the receive shifter
	typedef struct packed {
		logic [7:0] data;
		logic parity_bit;
		logic stop_bit;
	} ulsl_rx_char_t;

	// entry held in the receive fifo
	typedef struct packed {
		logic [7:0] data;
		logic parity_err;
		logic framing_err;
		logic brk;
	} ulsl_rx_entry_t;

	typedef enum logic [1:0] {
		ULSL_BRK_IDLE = 2'b00,
		ULSL_BRK_COUNT = 2'b01,
		ULSL_BRK_HELD = 2'b10
	} ulsl_brk_state_t;

endpackage

// [rtl/ulsl_rx_mem.sv]
// small memory of the receive fifo entries.
// assumes write and read pointers are managed by the caller.
`timescale 1ns/100ps
`default_nettype none
module ulsl_rx_mem (
	// clock
	input wire logic clk,
	// write side
	input wire logic wr_en,
	input wire logic [ulsl_pkg::ULSL_PTR_W-1:0] wr_ptr,
	input wire ulsl_pkg::ulsl_rx_entry_t wr_entry,
	// read side
	input wire logic [ulsl_pkg::ULSL_PTR_W-1:0] rd_ptr,
	output ulsl_pkg::ulsl_rx_entry_t rd_entry
);
	import ulsl_pkg::*;

	ulsl_rx_entry_t mem [ULSL_FIFO_DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_ptr] <= wr_entry;
		end
		if (wr_en && wr_ptr == rd_ptr) begin
			rd_entry <= wr_entry;
		end else begin
			rd_entry <= mem[rd_ptr];
		end
	end

endmodule
`default_nettype wire

// [rtl/ulsl_top.sv]
// uart line status logic with wishbone registers and an interrupt.
// assumes rx_char_valid and tx strobes are one-cycle pulses on clk;
// the serial receive input is asynchronous.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module ulsl_top (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// receive datapath
	input wire logic serial_in,
	input wire logic rx_char_valid,
	input wire ulsl_pkg::ulsl_rx_char_t rx_char,
	// transmit datapath
	input wire logic tx_holding_load,
	input wire logic tx_shift_load,
	input wire logic tx_fifo_empty,
	input wire logic tx_shift_empty,
	// interrupt and status
	output logic irq,
	output logic [7:0] line_status_reg
);
	import ulsl_pkg::*;
	logic [1:0] rx_sync;
	logic req, rd_lsr, rd_iir, rd_rbr, wr_ctrl, wr_mask, wr_stat;
	logic [4:0] ctrl;
	logic [2:0] irq_stat, irq_mask;
	logic [7:0] rx_buffer_reg;
	logic nf_full, push, pop, fifo_mode;
	logic [ULSL_PTR_W-1:0] wr_ptr, rd_ptr;
	logic [4:0] count, err_count;
	ulsl_rx_entry_t new_entry, head_entry;
	logic tx_holding_full, tx_holding_empty_flag, tx_holding_empty_flag_pend;
	logic overrun, parity_err_flag, framing_err_flag, break_flag;
	logic fifo_err, brk_event, line_err_event, parity_bad;
	logic [ULSL_BRK_W-1:0] brk_cnt;
	ulsl_brk_state_t brk_state;
	logic [3:0] iid;
	logic [31:0] next_dat;

	assign fifo_mode = ctrl[ULSL_C_FIFO_MODE];
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign rd_lsr = req && !wb_we_i && wb_adr_i == ULSL_ADR_LINE_STATUS;
	assign rd_iir = req && !wb_we_i && wb_adr_i == ULSL_ADR_INT_IDENT;
	assign rd_rbr = req && !wb_we_i && wb_adr_i == 8'h00;
	assign wr_ctrl = req && wb_we_i && wb_sel_i[0]
		&& wb_adr_i == ULSL_ADR_CTRL;
	assign wr_mask = req && wb_we_i && wb_sel_i[0]
		&& wb_adr_i == ULSL_ADR_IRQ_MASK;
	assign wr_stat = req && wb_we_i && wb_sel_i[0]
		&& wb_adr_i == ULSL_ADR_IRQ_STATUS;

	// serial input synchroniser
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_sync <= 2'h3;
		end else begin
			rx_sync <= {rx_sync[0], serial_in};
		end
	end

	// break detector: low for more than a full character time
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			brk_state <= ULSL_BRK_IDLE;
			brk_cnt <= '0;
		end else begin
			unique case (brk_state)
				ULSL_BRK_IDLE: begin
					brk_cnt <= '0;
					if (!rx_sync[1]) begin
						brk_state <= ULSL_BRK_COUNT;
					end
				end
				ULSL_BRK_COUNT: begin
					if (rx_sync[1]) begin
						brk_state <= ULSL_BRK_IDLE;
					end else if (brk_cnt == ULSL_BRK_W'(ULSL_CHAR_CYC)) begin
						brk_state <= ULSL_BRK_HELD;
					end else begin
						brk_cnt <= brk_cnt + 1'b1;
					end
				end
				ULSL_BRK_HELD: begin
					if (rx_sync[1]) begin
						brk_state <= ULSL_BRK_IDLE;
					end
				end
				default: begin
					brk_state <= ULSL_BRK_IDLE;
				end
			endcase
		end
	end

	assign brk_event = brk_state == ULSL_BRK_COUNT && !rx_sync[1]
		&& brk_cnt == ULSL_BRK_W'(ULSL_CHAR_CYC);

	// parity check against selected sense
	assign parity_bad = ctrl[ULSL_C_PARITY_ON]
		&& ((^rx_char.data ^ rx_char.parity_bit)
		!= !ctrl[ULSL_C_PARITY_EVEN]);

	assign new_entry.data = rx_char.data;
	assign new_entry.parity_err = parity_bad;
	assign new_entry.framing_err = !rx_char.stop_bit;
	assign new_entry.brk = brk_event;

	// receive fifo bookkeeping
	assign push = fifo_mode && rx_char_valid && count != ULSL_FIFO_FULL;
	assign pop = fifo_mode && rd_rbr && count != 5'h00;

	ulsl_rx_mem u_mem (
		.clk(clk),
		.wr_en(push),
		.wr_ptr(wr_ptr),
		.wr_entry(new_entry),
		.rd_ptr(pop ? rd_ptr + 1'b1 : rd_ptr),
		.rd_entry(head_entry)
	);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else if (!fifo_mode) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			count <= count + 5'(push) - 5'(pop);
		end
	end

	// count of errored entries still in the fifo
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			err_count <= '0;
		end else if (!fifo_mode) begin
			err_count <= '0;
		end else begin
			err_count <= err_count
				+ 5'(push && (new_entry.parity_err
				|| new_entry.framing_err || new_entry.brk))
				- 5'(pop && (head_entry.parity_err
				|| head_entry.framing_err || head_entry.brk));
		end
	end

	// non-fifo receive buffer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_buffer_reg <= '0;
			nf_full <= 1'b0;
		end else if (fifo_mode) begin
			nf_full <= 1'b0;
		end else if (rx_char_valid) begin
			rx_buffer_reg <= rx_char.data;
			nf_full <= 1'b1;
		end else if (rd_rbr) begin
			nf_full <= 1'b0;
		end
	end

	// line error flags; set wins over a clearing read
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			overrun <= 1'b0;
			parity_err_flag <= 1'b0;
			framing_err_flag <= 1'b0;
			break_flag <= 1'b0;
		end else begin
			if (rx_char_valid && (fifo_mode ? count == ULSL_FIFO_FULL
				: nf_full && !rd_rbr)) begin
				overrun <= 1'b1;
			end else if (rd_lsr) begin
				overrun <= 1'b0;
			end
			if (rx_char_valid && parity_bad) begin
				parity_err_flag <= 1'b1;
			end else if (rd_lsr) begin
				parity_err_flag <= 1'b0;
			end
			if (rx_char_valid && !rx_char.stop_bit) begin
				framing_err_flag <= 1'b1;
			end else if (rd_lsr) begin
				framing_err_flag <= 1'b0;
			end
			if (brk_event) begin
				break_flag <= 1'b1;
			end else if (rd_lsr) begin
				break_flag <= 1'b0;
			end
		end
	end

	assign line_err_event = brk_event || (rx_char_valid && (parity_bad
		|| !rx_char.stop_bit || (fifo_mode ? count == ULSL_FIFO_FULL
		: nf_full && !rd_rbr)));

	// fifo error summary
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fifo_err <= 1'b0;
		end else if (!fifo_mode) begin
			fifo_err <= 1'b0;
		end else if (push && (new_entry.parity_err
			|| new_entry.framing_err || new_entry.brk)) begin
			fifo_err <= 1'b1;
		end else if (rd_lsr && err_count == 5'h00) begin
			fifo_err <= 1'b0;
		end
	end
	// transmit holding state and its interrupt
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_holding_full <= 1'b0;
			tx_holding_empty_flag_pend <= 1'b0;
		end else begin
			if (tx_holding_load) begin
				tx_holding_full <= 1'b1;
			end else if (tx_shift_load) begin
				tx_holding_full <= 1'b0;
			end
			if (!fifo_mode && tx_shift_load && !tx_holding_load) begin
				tx_holding_empty_flag_pend <= 1'b1;
			end else if (fifo_mode && tx_fifo_empty && !tx_holding_empty_flag_pend
				&& tx_holding_full) begin
				tx_holding_empty_flag_pend <= 1'b1;
			end else if (rd_iir || tx_holding_load) begin
				tx_holding_empty_flag_pend <= 1'b0;
			end
		end
	end

	assign tx_holding_empty_flag = fifo_mode ? tx_fifo_empty
		: !tx_holding_full;

	// line status register image
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			line_status_reg <= ULSL_LSR_RESET;
		end else begin
			line_status_reg[ULSL_B_DATA_READY] <= fifo_mode
				? count != 5'h00 : nf_full;
			line_status_reg[ULSL_B_OVERRUN] <= overrun;
			line_status_reg[ULSL_B_PARITY] <= parity_err_flag;
			line_status_reg[ULSL_B_FRAMING] <= framing_err_flag;
			line_status_reg[ULSL_B_BREAK] <= break_flag;
			line_status_reg[ULSL_B_THR_EMPTY] <= tx_holding_empty_flag;
			line_status_reg[ULSL_B_TX_EMPTY] <= tx_holding_empty_flag
				&& tx_shift_empty;
			line_status_reg[ULSL_B_FIFO_ERR] <= fifo_err;
		end
	end

	// control register and sticky interrupt status
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl <= ULSL_CTRL_RESET;
			irq_mask <= ULSL_IRQ_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl <= wb_dat_i[4:0];
			end
			if (wr_mask) begin
				irq_mask <= wb_dat_i[2:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_stat <= ULSL_IRQ_RESET;
		end else begin
			irq_stat[ULSL_I_RLS] <= (line_err_event
				&& ctrl[ULSL_C_RLS_EN]) || (irq_stat[ULSL_I_RLS]
				&& !(wr_stat && wb_dat_i[ULSL_I_RLS]));
			irq_stat[ULSL_I_TX_HOLDING_EMPTY_FLAG] <= (tx_holding_empty_flag_pend && ctrl[ULSL_C_TX_HOLDING_EMPTY_FLAG_EN])
				|| (irq_stat[ULSL_I_TX_HOLDING_EMPTY_FLAG]
				&& !(wr_stat && wb_dat_i[ULSL_I_TX_HOLDING_EMPTY_FLAG]));
			irq_stat[ULSL_I_DATA] <= (push || (!fifo_mode && rx_char_valid))
				|| (irq_stat[ULSL_I_DATA]
				&& !(wr_stat && wb_dat_i[ULSL_I_DATA]));
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat & irq_mask);
		end
	end

	// interrupt identification, line status first
	always_comb begin
		if (ctrl[ULSL_C_RLS_EN] && (overrun || parity_err_flag
			|| framing_err_flag || break_flag)) begin
			iid = ULSL_IID_RLS;
		end else if (ctrl[ULSL_C_TX_HOLDING_EMPTY_FLAG_EN] && tx_holding_empty_flag_pend) begin
			iid = ULSL_IID_TX_HOLDING_EMPTY_FLAG;
		end else begin
			iid = ULSL_IID_NONE;
		end
	end

	// read mux
	always_comb begin
		next_dat = '0;
		unique case (wb_adr_i)
			8'h00: next_dat[7:0] = fifo_mode ? head_entry.data
				: rx_buffer_reg;
			ULSL_ADR_LINE_STATUS: next_dat[7:0] = line_status_reg;
			ULSL_ADR_INT_IDENT: next_dat[3:0] = iid;
			ULSL_ADR_CTRL: next_dat[4:0] = ctrl;
			ULSL_ADR_IRQ_STATUS: next_dat[2:0] = irq_stat;
			ULSL_ADR_IRQ_MASK: next_dat[2:0] = irq_mask;
			default: next_dat = '0;
		endcase
	end

	// single-cycle acknowledge
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= req ? next_dat : 32'h0000_0000;
		end
	end

endmodule
`default_nettype wire

// [testbench/ulsl_assertions.sv]
// concurrent checks of the uart line status block ports.
// assumes it is bound to ulsl_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module ulsl_assertions (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	// datapaths
	input wire logic rx_char_valid,
	input wire ulsl_pkg::ulsl_rx_char_t rx_char,
	input wire logic tx_holding_load,
	input wire logic tx_shift_load,
	input wire logic tx_fifo_empty,
	input wire logic tx_shift_empty,
	// status
	input wire logic [7:0] line_status_reg
);
	import ulsl_pkg::*;
	logic fifo_mode;
	logic ls_read;
	logic take;
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign ls_read = take && !wb_we_i && wb_adr_i == ULSL_ADR_LINE_STATUS;
	// mirror of the fifo mode bit
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fifo_mode <= 1'b0;
		end else if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == ULSL_ADR_CTRL) begin
			fifo_mode <= wb_dat_i[ULSL_C_FIFO_MODE];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_take;
		take;
	endsequence
	sequence s_read_quiet;
		ls_read && !rx_char_valid && !fifo_mode ##1 !rx_char_valid;
	endsequence
	bus_ack_a: assert property (s_take |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack is not a one cycle answer");
	tx_busy_a: assert property (
		!tx_shift_empty[*3] |-> !line_status_reg[ULSL_B_TX_EMPTY])
		else $error("tx empty while shifter busy");
	tx_both_a: assert property (
		line_status_reg[ULSL_B_TX_EMPTY] |-> line_status_reg[ULSL_B_THR_EMPTY])
		else $error("tx empty while holding full");
	fifo_err_zero_a: assert property (
		!fifo_mode[*3] |-> !line_status_reg[ULSL_B_FIFO_ERR])
		else $error("fifo error set outside fifo mode");
	hold_move_a: assert property (
		!fifo_mode && tx_shift_load && !tx_holding_load
		|-> ##2 line_status_reg[ULSL_B_THR_EMPTY])
		else $error("holding empty not set on move");
	hold_fifo_a: assert property (
		(fifo_mode && !tx_fifo_empty)[*3] |-> !line_status_reg[ULSL_B_THR_EMPTY])
		else $error("holding empty set with tx fifo data");
	data_ready_a: assert property (
		rx_char_valid |-> ##2 line_status_reg[ULSL_B_DATA_READY])
		else $error("data ready missing after char");
	frame_set_a: assert property (
		rx_char_valid && !rx_char.stop_bit && !fifo_mode
		|-> ##2 line_status_reg[ULSL_B_FRAMING])
		else $error("framing error not set");
	err_clear_a: assert property (
		s_read_quiet |=> !(|line_status_reg[ULSL_B_FRAMING:ULSL_B_PARITY]))
		else $error("errors not cleared by status read");
	set_wins_a: assert property (
		ls_read && rx_char_valid && !rx_char.stop_bit && !fifo_mode
		|-> ##2 line_status_reg[ULSL_B_FRAMING])
		else $error("new error lost to status read");
endmodule
bind ulsl_top ulsl_assertions ulsl_assertions_i (.clk, .rstn, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
	.rx_char_valid, .rx_char, .tx_holding_load, .tx_shift_load,
	.tx_fifo_empty, .tx_shift_empty, .line_status_reg);
`default_nettype wire

// [testbench/tb_top.sv]
// self-checking bench of the uart line status block.
// assumes the wishbone map and latencies of the package.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import ulsl_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hf;
	logic [3:0] wsel = 4'hf;
	logic [31:0] dat = 32'h0, rdat, q;
	logic ack, irq;
	logic serial_in = 1'b1, rxv = 1'b0;
	ulsl_rx_char_t rxc = '0;
	logic hload = 1'b0, sload = 1'b0, fempty = 1'b1, sempty = 1'b1;
	logic [7:0] ls_img;
	int n_fail = 0;
	int n_tests = 0;
	localparam logic [7:0] LS = ULSL_ADR_LINE_STATUS;
	always #50 clk = ~clk;
	ulsl_top ulsl_top_i (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.serial_in(serial_in), .rx_char_valid(rxv), .rx_char(rxc),
		.tx_holding_load(hload), .tx_shift_load(sload),
		.tx_fifo_empty(fempty), .tx_shift_empty(sempty), .irq(irq),
		.line_status_reg(ls_img));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= wsel;
		dat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
		wb(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask
	task automatic rx(input logic [7:0] d, input logic p, s);
		@(posedge clk);
		rxv <= 1'b1;
		rxc <= '{d, p, s};
		@(posedge clk);
		rxv <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic t_reset;
		rd(LS, 32'hff, 32'h60);
		chk({24'h0, ls_img}, 32'h60);
		wsel = 4'he;
		wb(1'b1, ULSL_ADR_CTRL, 32'h1f);
		wsel = 4'hf;
		rd(ULSL_ADR_CTRL, 32'hff, 32'h0);
		wb(1'b1, 8'h30, 32'hff);
		rd(8'h30, 32'hffffffff, 32'h0);
	endtask
	task automatic t_rx;
		wb(1'b1, ULSL_ADR_CTRL, 32'h18);
		wb(1'b1, ULSL_ADR_IRQ_MASK, 32'h1);
		rx(8'h00, 1'b0, 1'b0);
		rd(ULSL_ADR_IRQ_STATUS, 32'h1, 32'h0);
		rd(LS, 32'hff, 32'h69);
		rd(8'h00, 32'hff, 32'h00);
		wb(1'b1, ULSL_ADR_CTRL, 32'h1a);
		rx(8'h01, 1'b0, 1'b0);
		chk({31'h0, irq}, 32'h1);
		rd(LS, 32'hff, 32'h6d);
		rd(LS, 32'hff, 32'h61);
		wb(1'b1, ULSL_ADR_IRQ_STATUS, 32'h1);
		@(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rx(8'h03, 1'b0, 1'b1);
		rd(LS, 32'hff, 32'h63);
		rd(8'h00, 32'hff, 32'h03);
		fork
			rd(LS, 32'hff, 32'h60);
			rx(8'h00, 1'b0, 1'b0);
		join
		rd(LS, 32'hff, 32'h69);
		rd(8'h00, 32'hff, 32'h00);
		rd(LS, 32'hff, 32'h60);
		wb(1'b1, ULSL_ADR_CTRL, 32'h10);
		rx(8'h00, 1'b0, 1'b1);
		rd(LS, 32'hff, 32'h65);
		rd(8'h00, 32'hff, 32'h00);
		wb(1'b1, ULSL_ADR_IRQ_STATUS, 32'h7);
	endtask
	task automatic t_tx;
		wb(1'b1, ULSL_ADR_CTRL, 32'h04);
		wb(1'b1, ULSL_ADR_IRQ_MASK, 32'h2);
		@(posedge clk) hload <= 1'b1;
		@(posedge clk) hload <= 1'b0;
		rd(LS, 32'hff, 32'h00);
		@(posedge clk) sload <= 1'b1;
		sempty <= 1'b0;
		@(posedge clk) sload <= 1'b0;
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		rd(LS, 32'hff, 32'h20);
		rd(ULSL_ADR_INT_IDENT, 32'hf, {28'h0, ULSL_IID_TX_HOLDING_EMPTY_FLAG});
		rd(ULSL_ADR_INT_IDENT, 32'hf, {28'h0, ULSL_IID_NONE});
		sempty <= 1'b1;
		repeat (3) @(posedge clk);
		rd(LS, 32'hff, 32'h60);
		wb(1'b1, ULSL_ADR_IRQ_STATUS, 32'h7);
	endtask
	task automatic t_fifo;
		wb(1'b1, ULSL_ADR_CTRL, 32'h19);
		fempty <= 1'b0;
		repeat (3) @(posedge clk);
		rd(LS, 32'h60, 32'h0);
		fempty <= 1'b1;
		repeat (3) @(posedge clk);
		rd(LS, 32'h60, 32'h60);
		rx(8'h01, 1'b0, 1'b1);
		for (int i = 0; i < 16; i++) rx(8'h00, 1'b0, 1'b1);
		rd(LS, 32'h83, 32'h83);
		rd(LS, 32'h83, 32'h81);
		rd(8'h00, 32'hff, 32'h01);
		rd(LS, 32'hff, 32'he1);
		rd(LS, 32'h80, 32'h0);
		for (int i = 0; i < 15; i++) rd(8'h00, 32'hff, 32'h00);
		rd(LS, 32'hff, 32'h60);
		wb(1'b1, ULSL_ADR_CTRL, 32'h0);
	endtask
	task automatic t_brk;
		serial_in <= 1'b0;
		repeat (10400) @(posedge clk);
		rd(LS, 32'h10, 32'h0);
		repeat (40) @(posedge clk);
		rd(LS, 32'h10, 32'h10);
		serial_in <= 1'b1;
		repeat (3) @(posedge clk);
		rd(LS, 32'h10, 32'h0);
	endtask
	task automatic results;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_rx();
		t_tx();
		t_fifo();
		t_brk();
		results();
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		results();
	end
endmodule
`default_nettype wire
